/* pwm_period_trigger_deadtime.sv */
// Top: AXI4-Lite registers, time base, push-pull and complementary outputs
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/100ps
module pwm_period_trigger_deadtime (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic high_side_output,
    output logic low_side_output,
    output logic trigger_out,
    output logic pwm_irq
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    pwm_pkg::pwm_cfg_s cfg_reg, cfg_next;
    logic [15:0] period_pend_reg, period_pend_next;
    logic pend_reg, pend_next;
    logic [1:0] irq_en_reg, irq_en_next;
    logic [1:0] irq_flag_reg, irq_flag_next;
    logic aw_reg, aw_next, w_reg, w_next;
    logic [7:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // ------------------------------------------------------------
    // Time base state
    // ------------------------------------------------------------
    logic [15:0] count_reg, count_next;
    logic up_reg, up_next;
    logic side_reg, side_next;
    logic done_reg, done_next, lit_reg, lit_next;
    logic raw_hi, raw_lo, period_end, trig_pulse, sevt_hit, wr_fire, clr_fire;
    logic [15:0] shifted;
    logic dt_hi, dt_lo;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= pwm_pkg::status_off) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ------------------------------------------------------------
    // Time base and push-pull alternation
    // ------------------------------------------------------------
    assign period_end = cfg_reg.run && (cfg_reg.center ? (!up_reg && count_reg == '0)
                                        : (count_reg >= cfg_reg.period));
    // Phase offset wraps within the period
    assign shifted = ({1'b0, count_reg} + {1'b0, cfg_reg.phase} > {1'b0, cfg_reg.period})
                     ? 16'({1'b0, count_reg} + cfg_reg.phase - cfg_reg.period - 17'h1)
                     : 16'(count_reg + cfg_reg.phase);

    always_comb begin
        count_next = count_reg;
        up_next = up_reg;
        side_next = side_reg;
        if (!cfg_reg.run) begin
            count_next = '0;
            up_next = 1'b1;
            side_next = 1'b0;
        end else if (period_end) begin
            count_next = cfg_reg.center ? 16'h1 : '0;
            up_next = 1'b1;
            // Side advances only after a period that carried a pulse
            side_next = side_reg ^ done_reg;
        end else if (cfg_reg.center) begin
            if (up_reg && count_reg >= cfg_reg.period) begin
                up_next = 1'b0;
                count_next = count_reg - 1'b1;
            end else begin
                count_next = up_reg ? count_reg + 1'b1 : count_reg - 1'b1;
            end
        end else begin
            count_next = count_reg + 1'b1;
        end
    end

    always_comb begin
        raw_hi = 1'b0;
        raw_lo = 1'b0;
        done_next = 1'b0;
        lit_next = 1'b0;
        if (cfg_reg.run) begin
            if (cfg_reg.mode == pwm_pkg::mode_push_pull) begin
                // One pulse per period, never on the rollover cycle itself
                // A pulse cut by a period write is not restarted in that period
                lit_next = !period_end && (shifted < cfg_reg.duty) && (!done_reg || lit_reg);
                raw_hi = !side_reg && lit_next;
                raw_lo = side_reg && lit_next;
                done_next = !period_end && (done_reg || lit_next);
            end else begin
                raw_hi = shifted < cfg_reg.duty;
                raw_lo = !raw_hi;
            end
        end
    end

    pwm_dead_time #(.width(16)) u_dead (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .high_in(raw_hi),
        .low_in(raw_lo),
        .insert(cfg_reg.center && cfg_reg.mode == pwm_pkg::mode_complementary),
        .swap(cfg_reg.swap),
        .dead_time(cfg_reg.dead_time),
        .high_out(dt_hi),
        .low_out(dt_lo)
    );

    pwm_trigger u_trig (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .run(cfg_reg.run),
        .count(count_reg),
        .period_end(period_end),
        .compare(cfg_reg.trig_compare),
        .divider(cfg_reg.trig_div),
        .start_select(cfg_reg.trig_start),
        .trigger(trig_pulse)
    );

    assign sevt_hit = cfg_reg.run && count_reg == cfg_reg.sevt_compare;

    // ------------------------------------------------------------
    // AXI4-Lite slave and register file
    // ------------------------------------------------------------
    assign wr_fire = aw_reg && w_reg && !bvalid_reg;
    assign clr_fire = wr_fire && awaddr_reg == pwm_pkg::status_off && wstrb_reg[0];

    always_comb begin
        cfg_next = cfg_reg;
        period_pend_next = period_pend_reg;
        pend_next = pend_reg;
        irq_en_next = irq_en_reg;
        irq_flag_next = irq_flag_reg;
        aw_next = aw_reg;
        w_next = w_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_awvalid && !aw_reg) begin
            aw_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_reg) begin
            w_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        // Buffered period lands at the boundary
        if (pend_reg && period_end) begin
            cfg_next.period = period_pend_reg;
            pend_next = 1'b0;
        end
        if (clr_fire) irq_flag_next = irq_flag_reg & ~wdata_reg[1:0];
        // Set wins over a simultaneous clear
        if (sevt_hit && irq_en_reg[pwm_pkg::sevt_irq_en_bit]) irq_flag_next[0] = 1'b1;
        if (trig_pulse && irq_en_reg[pwm_pkg::trig_irq_en_bit]) irq_flag_next[1] = 1'b1;
        if (wr_fire) begin
            aw_next = 1'b0;
            w_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = mapped(awaddr_reg) ? pwm_pkg::resp_okay : pwm_pkg::resp_slverr;
            unique case (awaddr_reg)
                pwm_pkg::time_base_control_off: begin
                    if (wstrb_reg[1]) begin
                        cfg_next.run = wdata_reg[pwm_pkg::run_enable_bit];
                        cfg_next.immediate = wdata_reg[pwm_pkg::immediate_update_bit];
                    end
                end
                pwm_pkg::period_off: begin
                    if (cfg_reg.immediate || !cfg_reg.run) begin
                        cfg_next.period = merge16(cfg_reg.period, wdata_reg, wstrb_reg);
                        pend_next = 1'b0;
                    end else begin
                        period_pend_next = merge16(pend_reg ? period_pend_reg : cfg_reg.period,
                                                   wdata_reg, wstrb_reg);
                        pend_next = 1'b1;
                    end
                end
                pwm_pkg::output_control_off: begin
                    if (wstrb_reg[1]) cfg_next.mode = wdata_reg[pwm_pkg::mode_lsb +: 2];
                    if (wstrb_reg[0]) begin
                        cfg_next.swap = wdata_reg[pwm_pkg::swap_bit];
                        cfg_next.center = wdata_reg[pwm_pkg::center_bit];
                    end
                end
                pwm_pkg::phase_off: cfg_next.phase = merge16(cfg_reg.phase, wdata_reg, wstrb_reg);
                pwm_pkg::duty_off: cfg_next.duty = merge16(cfg_reg.duty, wdata_reg, wstrb_reg);
                pwm_pkg::dead_time_off: begin
                    cfg_next.dead_time = merge16(cfg_reg.dead_time, wdata_reg, wstrb_reg);
                end
                pwm_pkg::trigger_compare_off: begin
                    cfg_next.trig_compare = merge16(cfg_reg.trig_compare, wdata_reg, wstrb_reg);
                end
                pwm_pkg::trigger_control_off: begin
                    if (wstrb_reg[1]) cfg_next.trig_div = wdata_reg[pwm_pkg::trig_div_lsb +: 4];
                    if (wstrb_reg[0]) begin
                        cfg_next.trig_start = wdata_reg[pwm_pkg::trig_start_lsb +: 6];
                    end
                end
                pwm_pkg::special_event_off: begin
                    cfg_next.sevt_compare = merge16(cfg_reg.sevt_compare, wdata_reg, wstrb_reg);
                    if (wstrb_reg[2]) irq_en_next = wdata_reg[17:16];
                end
                default: ;
            endcase
        end
        if (bvalid_reg && s_axi_bready) bvalid_next = 1'b0;
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = mapped(s_axi_araddr) ? pwm_pkg::resp_okay : pwm_pkg::resp_slverr;
            rdata_next = '0;
            unique case (s_axi_araddr)
                pwm_pkg::time_base_control_off: begin
                    rdata_next[pwm_pkg::run_enable_bit] = cfg_reg.run;
                    rdata_next[pwm_pkg::immediate_update_bit] = cfg_reg.immediate;
                end
                pwm_pkg::period_off: rdata_next[15:0] = pend_reg ? period_pend_reg : cfg_reg.period;
                pwm_pkg::output_control_off: begin
                    rdata_next[pwm_pkg::mode_lsb +: 2] = cfg_reg.mode;
                    rdata_next[pwm_pkg::swap_bit] = cfg_reg.swap;
                    rdata_next[pwm_pkg::center_bit] = cfg_reg.center;
                end
                pwm_pkg::phase_off: rdata_next[15:0] = cfg_reg.phase;
                pwm_pkg::duty_off: rdata_next[15:0] = cfg_reg.duty;
                pwm_pkg::dead_time_off: rdata_next[15:0] = cfg_reg.dead_time;
                pwm_pkg::trigger_compare_off: rdata_next[15:0] = cfg_reg.trig_compare;
                pwm_pkg::trigger_control_off: begin
                    rdata_next[pwm_pkg::trig_div_lsb +: 4] = cfg_reg.trig_div;
                    rdata_next[pwm_pkg::trig_start_lsb +: 6] = cfg_reg.trig_start;
                end
                pwm_pkg::special_event_off: rdata_next = {14'h0, irq_en_reg, cfg_reg.sevt_compare};
                pwm_pkg::status_off: rdata_next = {count_reg, 11'h0, pend_reg, side_reg,
                                                   up_reg, irq_flag_reg};
                default: ;
            endcase
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cfg_reg <= '0;
            cfg_reg.period <= pwm_pkg::period_reset;
            period_pend_reg <= '0;
            pend_reg <= 1'b0;
            irq_en_reg <= '0;
            irq_flag_reg <= '0;
            aw_reg <= 1'b0;
            w_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= '0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= '0;
            count_reg <= '0;
            up_reg <= 1'b1;
            side_reg <= 1'b0;
            done_reg <= 1'b0;
            lit_reg <= 1'b0;
            high_side_output <= 1'b0;
            low_side_output <= 1'b0;
            trigger_out <= 1'b0;
            pwm_irq <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            period_pend_reg <= period_pend_next;
            pend_reg <= pend_next;
            irq_en_reg <= irq_en_next;
            irq_flag_reg <= irq_flag_next;
            aw_reg <= aw_next;
            w_reg <= w_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            count_reg <= count_next;
            up_reg <= up_next;
            side_reg <= side_next;
            done_reg <= done_next;
            lit_reg <= lit_next;
            high_side_output <= dt_hi;
            low_side_output <= dt_lo;
            trigger_out <= trig_pulse;
            pwm_irq <= |irq_flag_next;
        end
    end

    assign s_axi_awready = !aw_reg;
    assign s_axi_wready = !w_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence boundary_write_s;
        wr_fire && awaddr_reg == pwm_pkg::period_off && cfg_reg.run && !cfg_reg.immediate;
    endsequence
    deferred_period_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        boundary_write_s ##1 !period_end |=> $stable(cfg_reg.period))
        else $error("Period changed before boundary");
    push_pull_excl_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        cfg_reg.mode == pwm_pkg::mode_push_pull |-> !(raw_hi && raw_lo))
        else $error("Both push-pull outputs active");
    no_rollover_pulse_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        period_end && cfg_reg.mode == pwm_pkg::mode_push_pull |-> !raw_hi && !raw_lo)
        else $error("Pulse on rollover cycle");
    stopped_base_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        !cfg_reg.run |=> count_reg == '0) else $error("Time base ran while disabled");
    irq_set_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        sevt_hit && irq_en_reg[0] |=> irq_flag_reg[0] ##1 pwm_irq)
        else $error("Special event interrupt lost");
endmodule

/* pwm_pkg.sv */
// Package: register map, field positions, reset values and carrier types
package pwm_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] time_base_control_off = 8'h00;
    localparam logic [7:0] period_off = 8'h04;
    localparam logic [7:0] output_control_off = 8'h08;
    localparam logic [7:0] phase_off = 8'h0c;
    localparam logic [7:0] duty_off = 8'h10;
    localparam logic [7:0] dead_time_off = 8'h14;
    localparam logic [7:0] trigger_compare_off = 8'h18;
    localparam logic [7:0] trigger_control_off = 8'h1c;
    localparam logic [7:0] special_event_off = 8'h20;
    localparam logic [7:0] status_off = 8'h24;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int run_enable_bit = 15;
    localparam int immediate_update_bit = 10;
    localparam int mode_lsb = 10;
    localparam int swap_bit = 2;
    localparam int center_bit = 3;
    localparam int trig_div_lsb = 12;
    localparam int trig_start_lsb = 0;
    localparam int sevt_irq_en_bit = 0;
    localparam int trig_irq_en_bit = 1;

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] mode_push_pull = 2'h2;
    localparam logic [1:0] mode_complementary = 2'h0;
    localparam logic [15:0] period_reset = 16'hffff;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;

    typedef struct packed {
        logic run;
        logic immediate;
        logic [1:0] mode;
        logic center;
        logic swap;
        logic [15:0] period;
        logic [15:0] phase;
        logic [15:0] duty;
        logic [15:0] dead_time;
        logic [15:0] trig_compare;
        logic [3:0] trig_div;
        logic [5:0] trig_start;
        logic [15:0] sevt_compare;
    } pwm_cfg_s;

endpackage

/* pwm_dead_time.sv */
// Dead-time insertion and output swap on a complementary pair
`timescale 1ns/100ps
module pwm_dead_time #(
    parameter int width = 16
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic high_in,
    input wire logic low_in,
    input wire logic insert,
    input wire logic swap,
    input wire logic [width-1:0] dead_time,
    output logic high_out,
    output logic low_out
);
    logic [width-1:0] count_reg, count_next;
    logic high_reg, high_next, low_reg, low_next;
    logic hi_s, lo_s;

    if (width < 2) begin
        $error("width too small");
    end

    // Swap applies before dead time so guard interval survives swapping
    assign hi_s = swap ? low_in : high_in;
    assign lo_s = swap ? high_in : low_in;

    always_comb begin
        count_next = count_reg;
        high_next = hi_s;
        low_next = lo_s;
        if (insert) begin
            // Any rising edge waits out the dead time with both outputs low
            if ((hi_s && !high_reg) || (lo_s && !low_reg)) begin
                if (count_reg < dead_time) begin
                    count_next = count_reg + 1'b1;
                    high_next = 1'b0;
                    low_next = 1'b0;
                end
            end else begin
                count_next = '0;
            end
            if (hi_s && lo_s) begin
                high_next = 1'b0;
                low_next = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            count_reg <= '0;
            high_reg <= 1'b0;
            low_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            high_reg <= high_next;
            low_reg <= low_next;
        end
    end

    assign high_out = high_reg;
    assign low_out = low_reg;

    dead_gap_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        insert && !high_reg && !low_reg && (dead_time != '0) ##1 high_reg |-> $past(count_reg) != '0
            || $past(dead_time) == '0) else $error("Output rose without dead time");
endmodule

/* pwm_trigger.sv */
// Trigger compare with output divider and postscaler start delay
`timescale 1ns/100ps
module pwm_trigger (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic run,
    input wire logic [15:0] count,
    input wire logic period_end,
    input wire logic [15:0] compare,
    input wire logic [3:0] divider,
    input wire logic [5:0] start_select,
    output logic trigger
);
    logic [3:0] div_reg, div_next;
    logic [5:0] wait_reg, wait_next;
    logic trig_reg, trig_next;
    logic match;

    assign match = run && (count == compare);

    always_comb begin
        div_reg_next_default: begin
            div_next = div_reg;
            wait_next = wait_reg;
            trig_next = 1'b0;
        end
        if (!run) begin
            // Restart state so the divider counts from the first match after the start delay
            div_next = '0;
            wait_next = start_select;
        end else if (wait_reg != '0) begin
            if (period_end) wait_next = wait_reg - 1'b1;
        end else if (match) begin
            if (div_reg == divider) begin
                trig_next = 1'b1;
                div_next = '0;
            end else begin
                div_next = div_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_reg <= '0;
            wait_reg <= '0;
            trig_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            wait_reg <= wait_next;
            trig_reg <= trig_next;
        end
    end

    assign trigger = trig_reg;

    first_match_a: assert property (@(posedge clk_sys) disable iff (!resetn)
        match && wait_reg == '0 && div_reg == divider |=> trigger)
        else $error("Trigger missed on compare match");
endmodule

/* pwr_stage.sv */
// Power stage model watching the output pair
`timescale 1ns/100ps
module pwr_stage (
    input wire logic clk_sys,
    input wire logic hi,
    input wire logic lo,
    output int shoots
);
    initial shoots = 0;
    // Both switches on would short the supply rail
    always @(posedge clk_sys) begin
        if (hi === 1'b1 && lo === 1'b1) begin
            shoots <= shoots + 1;
        end
    end
endmodule

/* tb_top.sv */
// Bench: register bus driver, pulse monitor and trigger rate model
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, hi, lo, trg, irq, ph = 1'b0, pl = 1'b0;
    logic pp = 1'b0, last_hi = 1'b0;
    logic [1:0] bresp, rresp;
    logic [33:0] r;
    int failures = 0, checks = 0, cyc = 0, ntrg = 0, nhi = 0, nlo = 0, gap = 0, dt = 0;
    int shoots, n, t[3];
    always #2.5 clk_sys = ~clk_sys;
    pwm_period_trigger_deadtime dut (.clk_sys(clk_sys), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .high_side_output(hi), .low_side_output(lo), .trigger_out(trg), .pwm_irq(irq));
    pwr_stage ps (.clk_sys(clk_sys), .hi(hi), .lo(lo), .shoots(shoots));
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
    endtask
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_sys); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_sys); while (rvalid !== 1'b1);
        r = {rresp, rdata};
    endtask
    // Edge monitor: alternation in push-pull, dead-time gap otherwise
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
        ntrg <= ntrg + int'(trg === 1'b1);
        if ((hi && !ph) || (lo && !pl)) begin
            if (pp && nhi + nlo > 0 && last_hi === hi) chk(last_hi, !hi);
            if (!pp && gap < dt) chk(gap, dt);
            last_hi <= hi;
        end
        nhi <= nhi + int'(hi && !ph);
        nlo <= nlo + int'(lo && !pl);
        gap <= (hi || lo) ? 0 : gap + 1;
        ph <= hi;
        pl <= lo;
    end
    initial begin
        n = $urandom(32'ha44b3823);
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        rd_reg(pwm_pkg::period_off);
        chk(r, {pwm_pkg::resp_okay, 16'h0, pwm_pkg::period_reset});
        rd_reg(8'h40);
        chk(r, {pwm_pkg::resp_slverr, 32'h0});
        n = $urandom_range(16'hffff, 8);
        wr(pwm_pkg::phase_off, n);
        rd_reg(pwm_pkg::phase_off);
        chk(r, {pwm_pkg::resp_okay, n});
        wr(pwm_pkg::phase_off, $urandom_range(11, 8));
        wr(pwm_pkg::period_off, 32'h14);
        wr(pwm_pkg::duty_off, 32'h8);
        wr(pwm_pkg::output_control_off, 32'h800);
        pp = 1'b1;
        wr(pwm_pkg::time_base_control_off, 32'h8000);
        for (int i = 0; i < 24; i++) begin
            if (i == 12) wr(pwm_pkg::time_base_control_off, 32'h8400);
            repeat ($urandom_range(40)) @(posedge clk_sys);
            wr(pwm_pkg::period_off, $urandom_range(27, 12));
        end
        chk(nhi > 4 && nlo > 4, 1'b1);
        for (int d = 0; d < 3; d++) begin
            wr(pwm_pkg::trigger_compare_off, $urandom_range(7, 1));
            wr(pwm_pkg::trigger_control_off, d << 12);
            n = ntrg;
            repeat (1000) @(posedge clk_sys);
            t[d] = ntrg - n;
            if (t[d] > t[0] / (d + 1) + 1 || t[d] + 1 < t[0] / (d + 1) || t[0] < 9) chk(t[d], t[0] / (d + 1));
        end
        wr(pwm_pkg::special_event_off, 32'h30005);
        repeat (100) @(posedge clk_sys);
        rd_reg(pwm_pkg::status_off);
        chk({irq, r[1:0]}, 3'b111);
        wr(pwm_pkg::time_base_control_off, 32'h0);
        wr(pwm_pkg::status_off, 32'h3);
        n = ntrg + nhi + nlo;
        repeat (200) @(posedge clk_sys);
        chk({irq, ntrg + nhi + nlo}, {1'b0, n});
        dt = 3;
        pp = 1'b0;
        wr(pwm_pkg::dead_time_off, dt);
        wr(pwm_pkg::output_control_off, 32'hc);
        wr(pwm_pkg::time_base_control_off, 32'h8000);
        repeat (300) @(posedge clk_sys);
        wr(pwm_pkg::output_control_off, 32'h8);
        n = nhi + nlo;
        repeat (300) @(posedge clk_sys);
        chk({nhi + nlo > n, shoots}, {1'b1, 32'h0});
        report_and_stop();
    end
endmodule
